// File: ecppp_core.sv
/*
  Parallel host port core: data latch, address/command send path with
  forward strobe/busy handshake, reverse autofeed/ack capture, status
  mirror, control register and an Avalon-MM slave with waitrequest.
  Assumes peripheral inputs are synchronous to mclk and that the bench
  resolves the data bus wire from port_data_oe.
*/
`default_nettype none
module ecppp_core #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // peripheral inputs
  input wire logic peripheral_busy,
  input wire logic peripheral_ack_n,
  input wire logic paper_error,
  input wire logic peripheral_select,
  input wire logic peripheral_fault_n,
  // host outputs to the cable
  output logic host_strobe_n,
  output logic host_autofeed_n,
  output logic reverse_request_n,
  output logic host_active_n,
  // data bus, split into its three signals
  input wire logic [7:0] port_data_in,
  output logic [7:0] port_data_out,
  output logic port_data_oe,
  // interrupt request toward the host
  output logic host_irq
);
  initial begin
    if (ADDR_W < 5) begin
      $error("ADDR_W must be at least 5");
    end
  end

  logic [5:0] control_reg;
  logic [7:0] data_reg;
  logic [2:0] mode_reg;
  logic [7:0] fwd_byte_reg;
  logic fwd_full_reg;
  logic [8:0] rev_byte_reg;
  logic rev_valid_reg;
  logic ack_prev_reg;
  logic wait_reg;
  logic [31:0] readdata_reg;
  ecppp_pkg::ecppp_fwd_type fwd_state_reg;
  ecppp_pkg::ecppp_rev_type rev_state_reg;
  logic strobe_n_reg;
  logic autofeed_n_reg;
  logic init_n_reg;
  logic active_n_reg;
  logic [7:0] pd_out_reg;
  logic pd_oe_reg;
  logic irq_reg;

  logic [2:0] index;
  logic take_write;
  logic take_read;
  logic dir_eff;
  logic ecp_mode;
  logic [7:0] status_val;
  logic [7:0] control_val;
  logic [7:0] data_read_val;
  logic stall;
  logic [31:0] readdata_next;
  logic strobe_n_next;
  logic autofeed_n_next;
  logic active_n_next;
  logic [7:0] pd_out_next;
  logic pd_oe_next;

  assign index = avs_address[4:2];
  // a request takes effect only at the edge where waitrequest is low
  assign take_write = avs_write && !wait_reg;
  assign take_read = avs_read && !wait_reg;
  assign ecp_mode = (mode_reg == ecppp_pkg::MODE_ECP);
  // fifo mode is forward only, standard mode forces forward
  assign dir_eff = control_reg[ecppp_pkg::CTL_DIR]
    && (mode_reg != ecppp_pkg::MODE_STD) && (mode_reg != ecppp_pkg::MODE_FIFO);

  assign status_val = {~peripheral_busy,
    peripheral_ack_n, paper_error, peripheral_select, peripheral_fault_n,
    ecppp_pkg::STATUS_LOW_ONES};
  assign control_val = {ecppp_pkg::CTL_TOP_ONES,
    dir_eff, control_reg[4:0]};
  // bidirectional mode reading in input direction sees the wire
  assign data_read_val = (mode_reg == ecppp_pkg::MODE_BIDIR && dir_eff) ?
    port_data_in : data_reg;

  // an address byte waits while the send slot is still occupied
  assign stall = avs_write && (index == ecppp_pkg::IDX_DATA) && ecp_mode
    && !dir_eff && fwd_full_reg;

  always_comb begin
    readdata_next = 32'h0000_0000;
    case (index)
      ecppp_pkg::IDX_DATA: begin
        readdata_next[7:0] = data_read_val;
      end
      ecppp_pkg::IDX_STATUS: begin
        readdata_next[7:0] = status_val;
      end
      ecppp_pkg::IDX_CONTROL: begin
        readdata_next[7:0] = control_val;
      end
      ecppp_pkg::IDX_MODE: begin
        readdata_next[ecppp_pkg::MODE_MSB:ecppp_pkg::MODE_LSB] = mode_reg;
        readdata_next[ecppp_pkg::MODE_FWD_BUSY] = fwd_full_reg;
        readdata_next[ecppp_pkg::MODE_REV_VALID] = rev_valid_reg;
      end
      ecppp_pkg::IDX_REV: begin
        readdata_next[8:0] = rev_byte_reg;
      end
      default: begin
        readdata_next = 32'h0000_0000;
      end
    endcase
  end

  // bus handshake: one cycle to prepare, answer on the next
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if ((avs_read || avs_write) && !stall) begin
      wait_reg <= 1'b0;
      readdata_reg <= readdata_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      control_reg <= ecppp_pkg::CTL_RESET;
    end else if (take_write && index == ecppp_pkg::IDX_CONTROL && avs_byteenable[0]) begin
      control_reg <= avs_writedata[5:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= ecppp_pkg::MODE_RESET;
    end else if (take_write && index == ecppp_pkg::IDX_MODE && avs_byteenable[0]) begin
      mode_reg <= avs_writedata[ecppp_pkg::MODE_MSB:ecppp_pkg::MODE_LSB];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= ecppp_pkg::DATA_RESET;
    end else if (take_write && index == ecppp_pkg::IDX_DATA && avs_byteenable[0]
        && (mode_reg == ecppp_pkg::MODE_STD || mode_reg == ecppp_pkg::MODE_BIDIR)) begin
      data_reg <= avs_writedata[7:0];
    end
  end

  // send slot for address/command bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_byte_reg <= 8'h00;
      fwd_full_reg <= 1'b0;
    end else if (take_write && index == ecppp_pkg::IDX_DATA && avs_byteenable[0]
        && ecp_mode && !dir_eff) begin
      fwd_byte_reg <= avs_writedata[7:0];
      fwd_full_reg <= 1'b1;
    end else if (fwd_state_reg == ecppp_pkg::FWD_RELEASE && !peripheral_busy) begin
      fwd_full_reg <= 1'b0;
    end else if (!ecp_mode) begin
      fwd_full_reg <= 1'b0;
    end
  end
  // in reverse the write above is skipped, so the byte is dropped

  // forward handshake: strobe low, busy high, strobe high, busy low
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fwd_state_reg <= ecppp_pkg::FWD_IDLE;
    end else begin
      case (fwd_state_reg)
        ecppp_pkg::FWD_IDLE: begin
          if (ecp_mode && !dir_eff && fwd_full_reg && !peripheral_busy) begin
            fwd_state_reg <= ecppp_pkg::FWD_STROBE;
          end
        end
        ecppp_pkg::FWD_STROBE: begin
          if (peripheral_busy) begin
            fwd_state_reg <= ecppp_pkg::FWD_RELEASE;
          end
        end
        ecppp_pkg::FWD_RELEASE: begin
          if (!peripheral_busy) begin
            fwd_state_reg <= ecppp_pkg::FWD_IDLE;
          end
        end
        default: begin
          fwd_state_reg <= ecppp_pkg::FWD_IDLE;
        end
      endcase
    end
  end

  // reverse handshake, allowed once the peripheral acknowledged the turn
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rev_state_reg <= ecppp_pkg::REV_IDLE;
    end else if (!ecp_mode || !dir_eff) begin
      // leaving reverse ends the cycle and releases autofeed at once
      rev_state_reg <= ecppp_pkg::REV_IDLE;
    end else begin
      case (rev_state_reg)
        ecppp_pkg::REV_IDLE: begin
          if (!rev_valid_reg && !control_reg[ecppp_pkg::CTL_INIT]
              && !paper_error) begin
            rev_state_reg <= ecppp_pkg::REV_REQ;
          end
        end
        ecppp_pkg::REV_REQ: begin
          if (!peripheral_ack_n) begin
            rev_state_reg <= ecppp_pkg::REV_DONE;
          end
        end
        ecppp_pkg::REV_DONE: begin
          if (peripheral_ack_n) begin
            rev_state_reg <= ecppp_pkg::REV_IDLE;
          end
        end
        default: begin
          rev_state_reg <= ecppp_pkg::REV_IDLE;
        end
      endcase
    end
  end

  // captured byte holds busy as its command flag; set wins over read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rev_byte_reg <= 9'h000;
      rev_valid_reg <= 1'b0;
    end else if (rev_state_reg == ecppp_pkg::REV_REQ && !peripheral_ack_n
        && ecp_mode && dir_eff) begin
      rev_byte_reg <= {peripheral_busy, port_data_in};
      rev_valid_reg <= 1'b1;
    end else if (take_read && index == ecppp_pkg::IDX_REV) begin
      rev_valid_reg <= 1'b0;
    end
  end

  always_comb begin
    strobe_n_next = ~control_reg[ecppp_pkg::CTL_STROBE];
    autofeed_n_next = ~control_reg[ecppp_pkg::CTL_AUTOFD];
    active_n_next = ~control_reg[ecppp_pkg::CTL_SELIN];
    if (ecp_mode) begin
      active_n_next = 1'b1;
      if (fwd_state_reg == ecppp_pkg::FWD_STROBE) begin
        strobe_n_next = 1'b0;
      end
      if (!dir_eff && fwd_state_reg != ecppp_pkg::FWD_IDLE) begin
        autofeed_n_next = 1'b0;
      end
      if (rev_state_reg == ecppp_pkg::REV_REQ) begin
        autofeed_n_next = 1'b0;
      end else if (rev_state_reg == ecppp_pkg::REV_DONE) begin
        autofeed_n_next = 1'b1;
      end
    end
  end

  always_comb begin
    pd_out_next = data_reg;
    if (ecp_mode && fwd_full_reg) begin
      pd_out_next = fwd_byte_reg;
    end
    pd_oe_next = !dir_eff;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_n_reg <= 1'b1;
      autofeed_n_reg <= 1'b1;
      init_n_reg <= 1'b0;
      active_n_reg <= 1'b1;
      pd_out_reg <= 8'h00;
      pd_oe_reg <= 1'b1;
    end else begin
      strobe_n_reg <= strobe_n_next;
      autofeed_n_reg <= autofeed_n_next;
      init_n_reg <= control_reg[ecppp_pkg::CTL_INIT];
      active_n_reg <= active_n_next;
      pd_out_reg <= pd_out_next;
      pd_oe_reg <= pd_oe_next;
    end
  end

  // fault low is only mirrored in status; software decides direction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_prev_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      ack_prev_reg <= peripheral_ack_n;
      irq_reg <= control_reg[ecppp_pkg::CTL_IRQEN]
        && peripheral_ack_n && !ack_prev_reg;
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign host_strobe_n = strobe_n_reg;
  assign host_autofeed_n = autofeed_n_reg;
  assign reverse_request_n = init_n_reg;
  assign host_active_n = active_n_reg;
  assign port_data_out = pd_out_reg;
  assign port_data_oe = pd_oe_reg;
  assign host_irq = irq_reg;
endmodule
`default_nettype wire

// File: ecppp_pkg.sv
/*
  Shared constants for the parallel host port core: register indices,
  field positions, reset values, mode codes and handshake states.
  Assumes nothing of its surroundings; imported by scoped name only.
*/
`default_nettype none
package ecppp_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_CONTROL = 3'h2;
  localparam logic [2:0] IDX_MODE = 3'h3;
  localparam logic [2:0] IDX_REV = 3'h4;
  // device control field positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_AUTOFD = 1;
  localparam int CTL_INIT = 2;
  localparam int CTL_SELIN = 3;
  localparam int CTL_IRQEN = 4;
  localparam int CTL_DIR = 5;
  // mode control field positions and the reverse tag bit position
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int MODE_FWD_BUSY = 3;
  localparam int MODE_REV_VALID = 4;
  localparam int REV_TAG = 8;
  // fixed read values and reset values
  localparam logic [1:0] CTL_TOP_ONES = 2'h3;
  localparam logic [2:0] STATUS_LOW_ONES = 3'h7;
  localparam logic [5:0] CTL_RESET = 6'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] MODE_RESET = 3'h0;
  // operating modes
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  // handshake states, gray along the path
  typedef enum logic [1:0] {
    FWD_IDLE = 2'h0,
    FWD_STROBE = 2'h1,
    FWD_RELEASE = 2'h3
  } ecppp_fwd_type;
  typedef enum logic [1:0] {
    REV_IDLE = 2'h0,
    REV_REQ = 2'h1,
    REV_DONE = 2'h3
  } ecppp_rev_type;
endpackage
`default_nettype wire

// File: ecppp_core_properties.sv
/*
  Checker for the parallel host port core: pin levels against the
  control settings, and register answers against the cable inputs.
  Assumes it is bound to ecppp_core and hosts write byte lane 0.
*/
`default_nettype none
module ecppp_core_props #(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // cable
  input wire logic peripheral_busy,
  input wire logic peripheral_ack_n,
  input wire logic paper_error,
  input wire logic peripheral_select,
  input wire logic peripheral_fault_n,
  input wire logic host_strobe_n,
  input wire logic host_autofeed_n,
  input wire logic reverse_request_n,
  input wire logic host_active_n,
  input wire logic port_data_oe,
  input wire logic host_irq
);
  logic [5:0] ctl_reg;
  logic [2:0] mode_reg;
  logic [2:0] idx;
  logic wr_ok;
  logic rd_ok;
  assign idx = avs_address[4:2];
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_ok = avs_read && !avs_waitrequest;
  // shadows follow the core's own write edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) ctl_reg <= 6'h00;
    else if (wr_ok && idx == 3'h2) ctl_reg <= avs_writedata[5:0];
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) mode_reg <= 3'h0;
    else if (wr_ok && idx == 3'h3) mode_reg <= avs_writedata[2:0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_STATUS_PINS: assert property (rd_ok && idx == 3'h1 |-> avs_readdata[7:3] ==
    {~$past(peripheral_busy), $past(peripheral_ack_n), $past(paper_error),
    $past(peripheral_select), $past(peripheral_fault_n)}) else $error("status pins differ");
  AST_STATUS_ONES: assert property (rd_ok && idx == 3'h1 |-> avs_readdata[2:0] == 3'h7)
    else $error("status low bits not one");
  AST_CTL_READ: assert property (rd_ok && idx == 3'h2 |-> avs_readdata[7:6] == 2'h3
    && avs_readdata[4:0] == ctl_reg[4:0]) else $error("control read wrong");
  AST_DIR_OE: assert property (port_data_oe == !($past(ctl_reg[5]) &&
    $past(mode_reg) != 3'h0 && $past(mode_reg) != 3'h2)) else $error("bus direction wrong");
  AST_SEL_PIN: assert property (host_active_n ==
    ($past(mode_reg) == 3'h3 || !$past(ctl_reg[3]))) else $error("select-in pin wrong");
  AST_INIT_PIN: assert property (reverse_request_n == $past(ctl_reg[2]))
    else $error("init pin wrong");
  AST_STD_PINS: assert property ($past(mode_reg) == 3'h0 && $past(mode_reg, 2) == 3'h0
    |-> host_strobe_n == !$past(ctl_reg[0]) && host_autofeed_n == !$past(ctl_reg[1]))
    else $error("strobe or autofeed pin wrong");
  AST_IRQ_EDGE: assert property (host_irq |-> ($past(peripheral_ack_n, 2) &&
    !$past(peripheral_ack_n, 3) || $past(peripheral_ack_n) && !$past(peripheral_ack_n, 2))
    ##1 !host_irq) else $error("irq without ack rise");
  AST_BUS_ANSWER: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest
    ##1 avs_waitrequest) else $error("read answer timing wrong");
endmodule
bind ecppp_core ecppp_core_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// File: ecppp_periph.sv
/*
  Behavioural peripheral on the cable: forward busy handshake, reverse
  byte on ack. Assumes the bench resolves the data bus from both enables.
*/
`default_nettype none
module ecppp_periph (
  // clock
  input wire logic mclk,
  // host pins
  input wire logic host_strobe_n,
  input wire logic host_autofeed_n,
  input wire logic reverse_request_n,
  input wire logic host_active_n,
  input wire logic [7:0] port_data_in,
  // scenario control: reply delay, reverse command flag and byte
  input wire logic [3:0] dly,
  input wire logic [8:0] rev_word,
  // peripheral pins
  output logic peripheral_busy,
  output logic peripheral_ack_n,
  output logic paper_error,
  output logic [7:0] pd_drive,
  output logic pd_oe,
  // last forward byte with its autofeed level, toggle per byte
  output logic [8:0] rx_word,
  output logic rx_tgl
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    peripheral_busy = 1'b0;
    peripheral_ack_n = 1'b1;
    paper_error = 1'b1;
    pd_oe = 1'b0;
    rx_tgl = 1'b0;
  end
  always @(posedge mclk) paper_error <= reverse_request_n;
  always begin
    @(posedge mclk);
    if (!host_strobe_n) begin
      repeat (dly) @(posedge mclk);
      rx_word <= {host_autofeed_n, port_data_in};
      peripheral_busy <= 1'b1;
      while (!host_strobe_n) @(posedge mclk);
      peripheral_busy <= 1'b0;
      rx_tgl <= ~rx_tgl;
    end else if (!host_autofeed_n && !reverse_request_n && host_active_n) begin
      repeat (dly) @(posedge mclk);
      {peripheral_busy, pd_drive} <= rev_word;
      pd_oe <= 1'b1;
      @(posedge mclk);
      peripheral_ack_n <= 1'b0;
      while (!host_autofeed_n) @(posedge mclk);
      peripheral_ack_n <= 1'b1;
      pd_oe <= 1'b0;
      peripheral_busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: ecppp_core_tb_top.sv
/*
  Self-checking bench for the parallel host port core with a peripheral.
  Assumes the core answers each register access within a few cycles.
*/
`default_nettype none
module ecppp_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, e, seed = 32'h6a49;
  logic avs_waitrequest, peripheral_busy, peripheral_ack_n, paper_error, host_strobe_n;
  logic host_autofeed_n, reverse_request_n, host_active_n, port_data_oe, host_irq, pd_oe;
  logic rx_tgl, t;
  logic peripheral_select = 1'b0;
  logic peripheral_fault_n = 1'b1;
  logic [7:0] port_data_in, port_data_out, pd_drive;
  logic [3:0] dly = 4'h0;
  logic [8:0] rev_word = 9'h0, rx_word;
  logic [31:0] expq[$];
  int failures = 0, n_tests = 0, irq_cnt = 0, cyc = 0, k;
  // an undriven bus shows the inverse of port_data_out, not a kept value
  assign port_data_in = port_data_oe ? port_data_out : pd_oe ? pd_drive : ~port_data_out;
  always #2.5 mclk = ~mclk;
  ecppp_core uut (.*);
  ecppp_periph u_periph (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'h0};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 3000);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] idx, input logic [15:0] exp, input logic [15:0] msk);
    expq.push_back({msk, exp});
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic wt(input logic s, input logic v);
    int n;
    n = 0;
    while ((s ? rx_tgl : peripheral_ack_n) !== v && n < 500) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      chk(avs_readdata[15:0] & e[31:16], e[15:0]);
    end
    if (host_irq === 1'b1) irq_cnt++;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd(3'h2, 16'h00c0, 16'h00ff);
    rd(3'h0, 16'h0000, 16'h00ff);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      peripheral_select <= seed[0];
      peripheral_fault_n <= seed[1];
      rd(3'h1, {8'h0, 3'h6, seed[0], seed[1], 3'h7}, 16'h00ff);
      bus(1'b1, 3'h2, seed[15:8]);
      rd(3'h2, {8'h0, 3'h6, seed[12:8]}, 16'h00ff);
      bus(1'b1, 3'h2, 8'h00);
      bus(1'b1, 3'h0, seed[23:16]);
      rd(3'h0, {8'h0, seed[23:16]}, 16'h00ff);
      chk({8'h0, port_data_out}, {8'h0, seed[23:16]});
    end
    bus(1'b1, 3'h2, 8'h12);
    wt(1'b0, 1'b0);
    k = irq_cnt;
    bus(1'b1, 3'h2, 8'h10);
    bus(1'b1, 3'h2, 8'h02);
    wt(1'b0, 1'b0);
    bus(1'b1, 3'h2, 8'h00);
    repeat (6) @(posedge mclk);
    chk(16'(irq_cnt - k), 16'h0001);
    rd(3'h5, 16'h0000, 16'h00ff);
    bus(1'b1, 3'h2, 8'h04);
    bus(1'b1, 3'h3, 8'h03);
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      dly <= 4'(i * 5);
      t = rx_tgl;
      bus(1'b1, 3'h0, seed[7:0]);
      wt(1'b1, ~t);
      chk({7'h0, rx_word}, {8'h0, seed[7:0]});
    end
    rev_word <= seed[16:8];
    bus(1'b1, 3'h2, 8'h20);
    bus(1'b1, 3'h0, 8'h5a);
    rd(3'h3, 16'h0003, 16'h000f);
    wt(1'b0, 1'b0);
    wt(1'b0, 1'b1);
    rd(3'h3, 16'h0010, 16'h0010);
    rd(3'h4, {7'h0, seed[16:8]}, 16'h01ff);
    // bidirectional mode with input direction reads the undriven wire
    bus(1'b1, 3'h3, 8'h01);
    bus(1'b1, 3'h0, 8'ha5);
    rd(3'h0, 16'h005a, 16'h00ff);
    stop_test();
  end
endmodule
`default_nettype wire
